// ### qsfg_pkg.sv
// Package with constants and types for the questionable status filter group.
package qsfg_pkg;

    localparam int W = 16;

    // Register selectors on the command port.
    typedef enum logic [2:0] {
        SEL_QUEST_NEG_MASK,
        SEL_QUEST_POS_MASK,
        SEL_CAL_COND,
        SEL_CAL_ENABLE,
        SEL_CAL_EVENT,
        SEL_CAL_NEG_MASK,
        SEL_CAL_POS_MASK
    } qsfg_sel_t;

    typedef struct packed {
        logic valid;
        logic write;
        qsfg_sel_t sel;
        logic [W-1:0] wdata;
    } qsfg_cmd_t;

    typedef struct packed {
        logic valid;
        logic [W-1:0] rdata;
    } qsfg_rsp_t;

    // Bit positions.
    localparam int CAL_CH1_BIT = 2;
    localparam int CAL_CH2_BIT = 3;
    localparam int QUEST_CAL_SUMMARY_BIT = 8;

    // Condition bits that exist; all others read as zero.
    localparam logic [W-1:0] CAL_USED_MASK = 16'h000c;
    localparam logic [W-1:0] QUEST_USED_MASK = 16'h0108;

    // Preset and reset values.
    localparam logic [W-1:0] POS_MASK_PRESET = 16'hffff;
    localparam logic [W-1:0] NEG_MASK_PRESET = 16'h0000;
    localparam logic [W-1:0] CAL_ENABLE_PRESET = 16'hffff;
    localparam logic [W-1:0] ZERO16 = 16'h0000;

endpackage : qsfg_pkg

// ### qsfg_top.sv
// Questionable transition filters and the calibration status sub-group.
`timescale 1ns/1ps
module qsfg_top (
    input wire logic clk,
    input wire logic srst,
    input wire qsfg_pkg::qsfg_cmd_t cmd,
    input wire logic preset,
    input wire logic channel_one_fallback_table_flag,
    input wire logic channel_two_fallback_table_flag,
    input wire logic [15:0] quest_cond_in,
    output qsfg_pkg::qsfg_rsp_t rsp_q,
    output logic [15:0] quest_cond_q,
    output logic [15:0] quest_event_set_q,
    output logic quest_enable_clear_q
);

    logic [15:0] quest_prev_q;
    logic [15:0] quest_neg_q;
    logic [15:0] quest_pos_q;
    logic [15:0] cal_cond_q;
    logic [15:0] cal_prev_q;
    logic [15:0] cal_enable_q;
    logic [15:0] cal_event_q;
    logic [15:0] cal_neg_q;
    logic [15:0] cal_pos_q;

    wire wr = cmd.valid && cmd.write;
    wire rd = cmd.valid && !cmd.write;
    wire rd_cal_event = rd && cmd.sel == qsfg_pkg::SEL_CAL_EVENT;
    wire wr_qneg = wr && cmd.sel == qsfg_pkg::SEL_QUEST_NEG_MASK;
    wire wr_qpos = wr && cmd.sel == qsfg_pkg::SEL_QUEST_POS_MASK;
    wire wr_cen = wr && cmd.sel == qsfg_pkg::SEL_CAL_ENABLE;
    wire wr_cneg = wr && cmd.sel == qsfg_pkg::SEL_CAL_NEG_MASK;
    wire wr_cpos = wr && cmd.sel == qsfg_pkg::SEL_CAL_POS_MASK;

    // Live calibration status, unused positions forced to zero.
    wire [15:0] cal_flags = {12'h000, channel_two_fallback_table_flag,
        channel_one_fallback_table_flag, 2'h0};
    wire [15:0] cal_cond_d = cal_flags & qsfg_pkg::CAL_USED_MASK;

    wire [15:0] cal_rise = cal_cond_q & ~cal_prev_q;
    wire [15:0] cal_fall = ~cal_cond_q & cal_prev_q;
    wire [15:0] cal_set = (cal_rise & cal_pos_q) |
        (cal_fall & cal_neg_q);
    // A set arriving with the read-clear survives it.
    wire [15:0] cal_event_d = rd_cal_event ? cal_set :
        (cal_event_q | cal_set);
    wire cal_summary = |(cal_event_q & cal_enable_q);

    wire [15:0] quest_cond_d = (quest_cond_in & qsfg_pkg::QUEST_USED_MASK &
        ~(16'h0001 << qsfg_pkg::QUEST_CAL_SUMMARY_BIT)) |
        ({15'h0000, cal_summary} << qsfg_pkg::QUEST_CAL_SUMMARY_BIT);
    wire [15:0] quest_rise = quest_cond_q & ~quest_prev_q;
    wire [15:0] quest_fall = ~quest_cond_q & quest_prev_q;
    wire [15:0] quest_pos_hit = quest_rise & quest_pos_q;
    wire [15:0] quest_neg_hit = quest_fall & quest_neg_q;

    logic [15:0] rdata_d;
    always_comb begin
        case (cmd.sel)
            qsfg_pkg::SEL_QUEST_NEG_MASK: rdata_d = quest_neg_q;
            qsfg_pkg::SEL_QUEST_POS_MASK: rdata_d = quest_pos_q;
            qsfg_pkg::SEL_CAL_COND: rdata_d = cal_cond_q;
            qsfg_pkg::SEL_CAL_ENABLE: rdata_d = cal_enable_q;
            qsfg_pkg::SEL_CAL_EVENT: rdata_d = cal_event_q;
            qsfg_pkg::SEL_CAL_NEG_MASK: rdata_d = cal_neg_q;
            qsfg_pkg::SEL_CAL_POS_MASK: rdata_d = cal_pos_q;
            default: rdata_d = qsfg_pkg::ZERO16;
        endcase
    end

    // Status path.
    always_ff @(posedge clk) begin
        if (srst) begin
            cal_cond_q <= qsfg_pkg::ZERO16;
            cal_prev_q <= qsfg_pkg::ZERO16;
            cal_event_q <= qsfg_pkg::ZERO16;
            quest_cond_q <= qsfg_pkg::ZERO16;
            quest_prev_q <= qsfg_pkg::ZERO16;
            quest_event_set_q <= qsfg_pkg::ZERO16;
        end else begin
            cal_cond_q <= cal_cond_d;
            cal_prev_q <= cal_cond_q;
            cal_event_q <= cal_event_d;
            quest_cond_q <= quest_cond_d;
            quest_prev_q <= quest_cond_q;
            quest_event_set_q <= quest_pos_hit | quest_neg_hit;
        end
    end

    // Masks; preset overrides a write in the same cycle.
    always_ff @(posedge clk) begin
        if (srst || preset) begin
            quest_pos_q <= qsfg_pkg::POS_MASK_PRESET;
            quest_neg_q <= qsfg_pkg::NEG_MASK_PRESET;
            cal_pos_q <= qsfg_pkg::POS_MASK_PRESET;
            cal_neg_q <= qsfg_pkg::NEG_MASK_PRESET;
            cal_enable_q <= qsfg_pkg::CAL_ENABLE_PRESET;
        end else begin
            if (wr_qneg) quest_neg_q <= cmd.wdata;
            if (wr_qpos) quest_pos_q <= cmd.wdata;
            if (wr_cneg) cal_neg_q <= cmd.wdata;
            if (wr_cpos) cal_pos_q <= cmd.wdata;
            if (wr_cen) cal_enable_q <= cmd.wdata;
        end
    end

    // Command answers and the enable-clear pulse.
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_q <= '0;
            quest_enable_clear_q <= 1'b0;
        end else begin
            rsp_q.valid <= rd;
            rsp_q.rdata <= rd ? rdata_d : qsfg_pkg::ZERO16;
            quest_enable_clear_q <= preset;
        end
    end

    sequence s_cal_read;
        rd_cal_event;
    endsequence

    sequence s_answer_event;
        rsp_q.valid && rsp_q.rdata == $past(cal_event_q);
    endsequence

    property p_quest_neg;
        @(posedge clk) disable iff (srst)
        (|quest_neg_hit) |=>
            ((quest_event_set_q & $past(quest_neg_hit)) ==
             $past(quest_neg_hit));
    endproperty
    a_quest_neg: assert property (p_quest_neg)
        else $error("negative edge did not raise event");

    property p_quest_pos;
        @(posedge clk) disable iff (srst)
        $rose(quest_cond_q[3]) && quest_pos_q[3] |=> quest_event_set_q[3];
    endproperty
    a_quest_pos: assert property (p_quest_pos)
        else $error("positive edge did not raise event");

    property p_mask_write;
        @(posedge clk) disable iff (srst)
        wr_cen && !preset |=> cal_enable_q == $past(cmd.wdata);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not stored");

    property p_cal_live;
        @(posedge clk) disable iff (srst)
        1'b1 |=> cal_cond_q[2] == $past(channel_one_fallback_table_flag) &&
            cal_cond_q[3] == $past(channel_two_fallback_table_flag);
    endproperty
    a_cal_live: assert property (p_cal_live)
        else $error("calibration condition not live");

    property p_cal_read_now;
        @(posedge clk) disable iff (srst)
        rd && cmd.sel == qsfg_pkg::SEL_CAL_COND |=>
            rsp_q.rdata == $past(cal_cond_q);
    endproperty
    a_cal_read_now: assert property (p_cal_read_now)
        else $error("condition read stale");

    property p_summary;
        @(posedge clk) disable iff (srst)
        (|(cal_event_q & cal_enable_q)) |=>
            quest_cond_q[qsfg_pkg::QUEST_CAL_SUMMARY_BIT] ##1
            quest_prev_q[qsfg_pkg::QUEST_CAL_SUMMARY_BIT];
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary bit not set");

    property p_summary_edge;
        @(posedge clk) disable iff (srst)
        $rose(quest_cond_q[qsfg_pkg::QUEST_CAL_SUMMARY_BIT]) &&
            quest_pos_q[qsfg_pkg::QUEST_CAL_SUMMARY_BIT] |=>
            quest_event_set_q[qsfg_pkg::QUEST_CAL_SUMMARY_BIT];
    endproperty
    a_summary_edge: assert property (p_summary_edge)
        else $error("summary edge not filtered");

    property p_read_clear;
        @(posedge clk) disable iff (srst)
        s_cal_read |=> s_answer_event and
            (cal_event_q == $past(cal_set));
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("event read did not clear");

    property p_cal_latch;
        @(posedge clk) disable iff (srst)
        (|(cal_prev_q & ~cal_cond_q & cal_neg_q)) |=>
            (cal_event_q & $past(cal_prev_q & ~cal_cond_q & cal_neg_q)) ==
            $past(cal_prev_q & ~cal_cond_q & cal_neg_q);
    endproperty
    a_cal_latch: assert property (p_cal_latch)
        else $error("calibration fall not latched in all bits");

    property p_cal_neg;
        @(posedge clk) disable iff (srst)
        cal_fall[2] && cal_neg_q[2] |=> cal_event_q[2];
    endproperty
    a_cal_neg: assert property (p_cal_neg)
        else $error("calibration fall not latched");

    property p_cal_pos;
        @(posedge clk) disable iff (srst)
        cal_rise[3] && cal_pos_q[3] |=> cal_event_q[3];
    endproperty
    a_cal_pos: assert property (p_cal_pos)
        else $error("calibration rise not latched");

    property p_preset;
        @(posedge clk) disable iff (srst)
        preset |=> quest_pos_q == qsfg_pkg::POS_MASK_PRESET &&
            quest_neg_q == qsfg_pkg::NEG_MASK_PRESET &&
            cal_pos_q == qsfg_pkg::POS_MASK_PRESET &&
            cal_neg_q == qsfg_pkg::NEG_MASK_PRESET &&
            cal_enable_q == qsfg_pkg::CAL_ENABLE_PRESET && quest_enable_clear_q;
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset values wrong");

    property p_unused;
        @(posedge clk) disable iff (srst)
        (cal_cond_q & ~qsfg_pkg::CAL_USED_MASK) == 16'h0000 &&
            (cal_event_q & ~qsfg_pkg::CAL_USED_MASK) == 16'h0000;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit set");

    property p_hold;
        @(posedge clk) disable iff (srst)
        !rd_cal_event |=>
            (cal_event_q & $past(cal_event_q)) == $past(cal_event_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("event bit lost");

endmodule : qsfg_top

// ### tb_top.sv
// Self-checking testbench for the questionable status filter group.
`timescale 1ns/1ps
module tb_top;
    localparam qsfg_pkg::qsfg_sel_t QN = qsfg_pkg::SEL_QUEST_NEG_MASK;
    localparam qsfg_pkg::qsfg_sel_t QP = qsfg_pkg::SEL_QUEST_POS_MASK;
    localparam qsfg_pkg::qsfg_sel_t CC = qsfg_pkg::SEL_CAL_COND;
    localparam qsfg_pkg::qsfg_sel_t CE = qsfg_pkg::SEL_CAL_ENABLE;
    localparam qsfg_pkg::qsfg_sel_t CV = qsfg_pkg::SEL_CAL_EVENT;
    localparam qsfg_pkg::qsfg_sel_t CN = qsfg_pkg::SEL_CAL_NEG_MASK;
    localparam qsfg_pkg::qsfg_sel_t CP = qsfg_pkg::SEL_CAL_POS_MASK;
    logic clk = 1'b0;
    logic srst = 1'b1;
    qsfg_pkg::qsfg_cmd_t cmd = '0;
    logic preset = 1'b0;
    logic f1 = 1'b0;
    logic f2 = 1'b0;
    logic q3 = 1'b0;
    logic [15:0] quest_cond_in = 16'h0000;
    qsfg_pkg::qsfg_rsp_t rsp_q;
    logic [15:0] quest_cond_q;
    logic [15:0] quest_event_set_q;
    logic quest_enable_clear_q;
    logic [15:0] seen_ev = 16'h0000;
    logic seen_clr = 1'b0;
    logic [15:0] v;
    logic [15:0] mk[5];
    logic clr_ev = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    qsfg_pkg::qsfg_sel_t ws[5] = '{QN, QP, CE, CN, CP};

    qsfg_top uut (.clk(clk), .srst(srst), .cmd(cmd), .preset(preset),
        .channel_one_fallback_table_flag(f1),
        .channel_two_fallback_table_flag(f2),
        .quest_cond_in(quest_cond_in), .rsp_q(rsp_q),
        .quest_cond_q(quest_cond_q), .quest_event_set_q(quest_event_set_q),
        .quest_enable_clear_q(quest_enable_clear_q));

    always #5 clk = ~clk;

    // Unused questionable sources get noise; pulses are caught sticky.
    // A high clr_ev restarts both captures.
    always @(posedge clk) begin
        quest_cond_in <= (16'($urandom) & 16'hfff7) | {12'h000, q3, 3'b000};
        seen_ev <= (clr_ev ? 16'h0000 : seen_ev) | quest_event_set_q;
        seen_clr <= (clr_ev ? 1'b0 : seen_clr) | quest_enable_clear_q;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            summarize();
        end
    end

    function automatic logic [15:0] cal_exp(input logic a, input logic b);
        return {12'h000, b, a, 2'b00};
    endfunction : cal_exp

    task automatic check(input string n, input logic [15:0] s,
                         input logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(input qsfg_pkg::qsfg_sel_t s, input logic [15:0] d);
        @(posedge clk);
        cmd <= {1'b1, 1'b1, s, d};
        @(posedge clk);
        cmd <= '0;
    endtask : wr

    task automatic rdchk(input qsfg_pkg::qsfg_sel_t s, input logic [15:0] e,
                         input string n);
        @(posedge clk);
        cmd <= {1'b1, 1'b0, s, 16'h0000};
        @(posedge clk);
        cmd <= '0;
        #1;
        check("rsp_valid", 16'(rsp_q.valid), 16'h0001);
        check(n, rsp_q.rdata, e);
    endtask : rdchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        void'($urandom(26971));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rdchk(QP, 16'hffff, "qpos");
        rdchk(QN, 16'h0000, "qneg");
        rdchk(CE, 16'hffff, "cen");
        rdchk(CP, 16'hffff, "cpos");
        rdchk(CN, 16'h0000, "cneg");
        for (int i = 0; i < 10; i++) begin
            v = (i < 5) ? 16'hffff : 16'($urandom);
            mk[i % 5] = v;
            wr(ws[i % 5], v);
            rdchk(ws[i % 5], v, "mask");
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            f1 <= i[0];
            f2 <= i[1];
            idle(3);
            rdchk(CC, cal_exp(i[0], i[1]), "cal_cond");
        end
        wr(CC, 16'h0000);
        rdchk(CC, cal_exp(1'b1, 1'b1), "cal_cond_ro");
        wr(CP, 16'hffff);
        wr(CN, 16'h0000);
        wr(CE, 16'h0000);
        wr(QP, 16'h0100);
        wr(QN, 16'h0000);
        @(posedge clk);
        f1 <= 1'b0;
        f2 <= 1'b0;
        idle(4);
        // Random masks saw channel one rise, fall, rise and channel two rise.
        v = cal_exp(mk[4][2] | mk[3][2], mk[4][3]);
        rdchk(CV, v, "cal_ev_clr");
        idle(4);
        rdchk(CV, 16'h0000, "cal_ev_fall");
        @(posedge clk);
        f1 <= 1'b1;
        idle(6);
        check("sum_off", 16'(quest_cond_q[8]), 16'h0000);
        rdchk(CV, 16'h0004, "cal_ev_rise");
        rdchk(CV, 16'h0000, "cal_ev_read");
        wr(CP, 16'h0000);
        wr(CN, 16'h0008);
        wr(CE, 16'h0008);
        @(posedge clk);
        f2 <= 1'b1;
        idle(6);
        rdchk(CV, 16'h0000, "cal_ev_nopos");
        clr_ev <= 1'b1;
        @(posedge clk);
        clr_ev <= 1'b0;
        f2 <= 1'b0;
        idle(8);
        check("sum_on", 16'(quest_cond_q[8]), 16'h0001);
        check("sum_ev", 16'(seen_ev[8]), 16'h0001);
        rdchk(CV, 16'h0008, "cal_ev_neg");
        idle(4);
        check("sum_clr", 16'(quest_cond_q[8]), 16'h0000);
        wr(QP, 16'h0000);
        wr(QN, 16'h0008);
        clr_ev <= 1'b1;
        @(posedge clk);
        clr_ev <= 1'b0;
        q3 <= 1'b1;
        idle(5);
        check("q_cond", quest_cond_q, 16'h0008);
        check("q_nopos", seen_ev, 16'h0000);
        @(posedge clk);
        q3 <= 1'b0;
        idle(5);
        check("q_neg", seen_ev, 16'h0008);
        wr(QP, 16'h0008);
        wr(QN, 16'h0000);
        clr_ev <= 1'b1;
        @(posedge clk);
        clr_ev <= 1'b0;
        q3 <= 1'b1;
        idle(5);
        check("q_pos", seen_ev, 16'h0008);
        wr(QN, 16'($urandom));
        wr(CE, 16'h0000);
        clr_ev <= 1'b1;
        @(posedge clk);
        clr_ev <= 1'b0;
        preset <= 1'b1;
        @(posedge clk);
        preset <= 1'b0;
        idle(3);
        check("en_clr", 16'(seen_clr), 16'h0001);
        rdchk(QP, 16'hffff, "qpos_p");
        rdchk(QN, 16'h0000, "qneg_p");
        rdchk(CE, 16'hffff, "cen_p");
        rdchk(CP, 16'hffff, "cpos_p");
        rdchk(CN, 16'h0000, "cneg_p");
        // Mid-run reset must drop a latched event and restore the QN mask.
        wr(QN, 16'h00ff);
        @(posedge clk);
        f2 <= 1'b1;
        idle(4);
        @(posedge clk);
        srst <= 1'b1;
        f2 <= 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rdchk(CV, 16'h0000, "cal_ev_rst");
        rdchk(QN, 16'h0000, "qneg_r");
        summarize();
    end
endmodule : tb_top
